// ==== rtl/rfb_pkg.sv ====
// Operation
// - Base field compares address bits 20-31; low bits ignored for big blocks.
// - Power-up or local reset loads block A base with ff0.
// - Power-up or local reset loads block B base with ff4.
// - Size code doubles 1MB at 000 to 64MB at 110; 111 reserved.
// - Wide flag clear: two 8-bit devices; set: 32-bit pair or 64-bit.
// - Block A wide flag follows its strap at power-up; not writable.
// - Top range goes to neither, A when only A set, B whenever B set.
// - A only selected: first megabyte of A also answers in top range.
// - B selected: first megabyte of B also answers in top range.
// - Block A vector select loads from its strap at power-up.
// - Base range claimed only when enabled; all reads terminate normally.
// - Narrow: only byte writes; wide: only aligned words; others unanswered.
// - Valid write terminates; reaches the device only when write enabled.
// - Block B wide flag and vector select load inverted straps.
// - Block B enable and write enable gate like block A.
package rfb_pkg;
  localparam logic [31:0] ADDR_CFG_A   = 32'hfef80050;
  localparam logic [31:0] ADDR_CFG_B   = 32'hfef80058;
  localparam int          BASE_MSB     = 31;
  localparam int          BASE_LSB     = 20;
  localparam int          SIZ_MSB      = 18;
  localparam int          SIZ_LSB      = 16;
  localparam int          BIT_WIDE     = 8;
  localparam int          BIT_VSEL     = 2;
  localparam int          BIT_EN       = 1;
  localparam int          BIT_WE       = 0;
  localparam logic [11:0] BASE_A_RST   = 12'hff0;
  localparam logic [11:0] BASE_B_RST   = 12'hff4;
  localparam logic [2:0]  SIZ_RST      = 3'h0;
  localparam logic [2:0]  SIZ_RESERVED = 3'h7;
  localparam logic [11:0] TOP_RANGE    = 12'hfff;
  localparam logic [5:0]  XFER_BYTE    = 6'h01;
  localparam logic [5:0]  XFER_WORD    = 6'h04;
  localparam logic [1:0]  STRAP_WAIT   = 2'h2;
endpackage : rfb_pkg

// ==== rtl/rfb_block_dec.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfb_block_dec (
  input  wire logic [31:0] addr,
  input  wire logic [11:0] base,
  input  wire logic [2:0]  siz,
  input  wire logic        en,
  input  wire logic        vec_on,
  output logic             hit,
  output logic             top_hit,
  output logic [25:0]      offset
);
  logic [11:0] cmp_mask;
  logic [25:0] off_mask;
  logic        base_hit;
  logic        in_top;

  assign cmp_mask = 12'hfff << siz;
  assign off_mask = ~(26'h3f00000 << siz);
  assign base_hit = (((addr[31:20] ^ base) & cmp_mask) == 12'h000)
                    && (siz != rfb_pkg::SIZ_RESERVED)
                    && en;
  assign in_top   = addr[31:20] == rfb_pkg::TOP_RANGE;
  assign top_hit  = vec_on && in_top;
  assign hit      = base_hit || top_hit;
  assign offset   = top_hit ? {6'h00, addr[19:0]} : (addr[25:0] & off_mask);
endmodule : rfb_block_dec
`default_nettype wire

// ==== rtl/rfb_rom_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfb_rom_decode (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        strap_a_vector_pin,
  input  wire logic        strap_a_width_pin,
  input  wire logic        strap_b_vector_pin,
  input  wire logic        strap_b_width_pin,
  input  wire logic        bus_valid,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic [5:0]  bus_size,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata,
  output logic             dev_sel_a,
  output logic             dev_sel_b,
  output logic             dev_write,
  output logic             dev_wide,
  output logic [25:0]      dev_offset
);
  logic [3:0]  strap_s1;
  logic [3:0]  strap_s2;
  logic [1:0]  strap_cnt;
  logic        wide_a;
  logic        wide_b;
  logic        block_a_vector_select;
  logic        block_b_vector_select;
  logic [11:0] base_a;
  logic [11:0] base_b;
  logic [2:0]  siz_a;
  logic [2:0]  siz_b;
  logic        en_a;
  logic        en_b;
  logic        we_a;
  logic        we_b;

  logic        hit_a;
  logic        hit_b;
  logic        top_a;
  logic        top_b;
  logic [25:0] off_a;
  logic [25:0] off_b;
  logic        pick_a;
  logic        pick_b;
  logic        sel_wide;
  logic        sel_we;
  logic        wr_ok;
  logic        reg_a;
  logic        reg_b;
  logic        reg_wr_a;
  logic        reg_wr_b;
  logic        blk_ack;
  logic        next_ack;
  logic        next_dev_write;
  logic [31:0] cfg_a;
  logic [31:0] cfg_b;
  logic [31:0] next_rdata;
  logic        strap_take;

  // Strap pins through two flops
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
    end else begin
      strap_s1 <= {strap_b_width_pin, strap_b_vector_pin,
                   strap_a_width_pin, strap_a_vector_pin};
      strap_s2 <= strap_s1;
    end
  end

  assign strap_take = strap_cnt == rfb_pkg::STRAP_WAIT;

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      wide_a <= 1'b0;
      wide_b <= 1'b0;
    end else if (strap_take) begin
      wide_a <= strap_s2[1];
      wide_b <= ~strap_s2[3];
    end
  end

  assign cfg_a = {base_a, 1'b0, siz_a, 7'h00, wide_a, 5'h00,
                  block_a_vector_select, en_a, we_a};
  assign cfg_b = {base_b, 1'b0, siz_b, 7'h00, wide_b, 5'h00,
                  block_b_vector_select, en_b, we_b};

  assign reg_a    = bus_valid && (bus_addr == rfb_pkg::ADDR_CFG_A);
  assign reg_b    = bus_valid && (bus_addr == rfb_pkg::ADDR_CFG_B);
  assign reg_wr_a = reg_a && bus_write;
  assign reg_wr_b = reg_b && bus_write;

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      block_a_vector_select <= 1'b0;
      block_b_vector_select <= 1'b0;
    end else if (strap_take) begin
      block_a_vector_select <= strap_s2[0];
      block_b_vector_select <= ~strap_s2[2];
    end else begin
      if (reg_wr_a) begin
        block_a_vector_select <= bus_wdata[rfb_pkg::BIT_VSEL];
      end
      if (reg_wr_b) begin
        block_b_vector_select <= bus_wdata[rfb_pkg::BIT_VSEL];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_a <= rfb_pkg::BASE_A_RST;
      siz_a  <= rfb_pkg::SIZ_RST;
      en_a   <= 1'b0;
      we_a   <= 1'b0;
    end else if (reg_wr_a) begin
      base_a <= bus_wdata[rfb_pkg::BASE_MSB:rfb_pkg::BASE_LSB];
      siz_a  <= bus_wdata[rfb_pkg::SIZ_MSB:rfb_pkg::SIZ_LSB];
      en_a   <= bus_wdata[rfb_pkg::BIT_EN];
      we_a   <= bus_wdata[rfb_pkg::BIT_WE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_b <= rfb_pkg::BASE_B_RST;
      siz_b  <= rfb_pkg::SIZ_RST;
      en_b   <= 1'b0;
      we_b   <= 1'b0;
    end else if (reg_wr_b) begin
      base_b <= bus_wdata[rfb_pkg::BASE_MSB:rfb_pkg::BASE_LSB];
      siz_b  <= bus_wdata[rfb_pkg::SIZ_MSB:rfb_pkg::SIZ_LSB];
      en_b   <= bus_wdata[rfb_pkg::BIT_EN];
      we_b   <= bus_wdata[rfb_pkg::BIT_WE];
    end
  end

  // A alias only while B clear
  rfb_block_dec u_dec_a (
    .addr    (bus_addr),
    .base    (base_a),
    .siz     (siz_a),
    .en      (en_a),
    .vec_on  (block_a_vector_select && !block_b_vector_select),
    .hit     (hit_a),
    .top_hit (top_a),
    .offset  (off_a)
  );

  rfb_block_dec u_dec_b (
    .addr    (bus_addr),
    .base    (base_b),
    .siz     (siz_b),
    .en      (en_b),
    .vec_on  (block_b_vector_select),
    .hit     (hit_b),
    .top_hit (top_b),
    .offset  (off_b)
  );

  // Vector alias beats a base match; otherwise A first
  assign pick_a   = hit_a && !top_b && !reg_a && !reg_b;
  assign pick_b   = hit_b && !pick_a && !reg_a && !reg_b;
  assign sel_wide = pick_b ? wide_b : wide_a;
  assign sel_we   = pick_b ? we_b : we_a;

  assign wr_ok = sel_wide ? ((bus_size == rfb_pkg::XFER_WORD)
                             && (bus_addr[1:0] == 2'h0))
                          : (bus_size == rfb_pkg::XFER_BYTE);

  assign blk_ack  = bus_valid && (pick_a || pick_b)
                    && (!bus_write || wr_ok);
  assign next_ack = blk_ack || reg_a || reg_b;
  assign next_dev_write = blk_ack && bus_write && sel_we;
  assign next_rdata = reg_a ? cfg_a : (reg_b ? cfg_b : 32'h00000000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack    <= 1'b0;
      bus_rdata  <= 32'h00000000;
      dev_sel_a  <= 1'b0;
      dev_sel_b  <= 1'b0;
      dev_write  <= 1'b0;
      dev_wide   <= 1'b0;
      dev_offset <= 26'h0000000;
    end else begin
      bus_ack    <= next_ack;
      bus_rdata  <= next_rdata;
      dev_sel_a  <= blk_ack && pick_a;
      dev_sel_b  <= blk_ack && pick_b;
      dev_write  <= next_dev_write;
      dev_wide   <= sel_wide;
      dev_offset <= pick_b ? off_b : off_a;
    end
  end
endmodule : rfb_rom_decode
`default_nettype wire

// ==== sim/rfb_rom_decode_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfb_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        por_n,
  input wire logic        bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic        bus_write,
  input wire logic [5:0]  bus_size,
  input wire logic        bus_ack,
  input wire logic        dev_sel_a,
  input wire logic        dev_sel_b,
  input wire logic        dev_write,
  input wire logic        dev_wide,
  input wire logic [25:0] dev_offset
);
  logic [19:0] last_low;
  always_ff @(posedge clk) last_low <= bus_addr[19:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);
  sequence top_read;
    bus_valid && !bus_write && bus_addr[31:20] == 12'hfff;
  endsequence
  sequence claimed;
    dev_sel_a || dev_sel_b;
  endsequence
  a_ack_after_valid: assert property (bus_ack |-> $past(bus_valid))
    else $error("ack without request");
  a_one_block: assert property (!(dev_sel_a && dev_sel_b))
    else $error("both blocks selected");
  a_claim_acked: assert property (claimed |-> bus_ack)
    else $error("claim without ack");
  a_write_claimed: assert property (dev_write |-> claimed)
    else $error("device write without claim");
  a_read_no_write: assert property (bus_valid && !bus_write
    |=> !dev_write)
    else $error("read wrote device");
  a_narrow_byte: assert property (bus_valid && bus_write &&
    bus_size != rfb_pkg::XFER_BYTE |=> !(dev_write && !dev_wide))
    else $error("narrow write not byte");
  a_wide_word: assert property (bus_valid && bus_write &&
    (bus_size != rfb_pkg::XFER_WORD || bus_addr[1:0] != 2'h0)
    |=> !(dev_write && dev_wide))
    else $error("wide write not aligned word");
  a_big_unclaimed: assert property (bus_valid && bus_write &&
    bus_size > 6'h04 |=> !dev_sel_a && !dev_sel_b)
    else $error("large write claimed");
  a_top_offset: assert property (top_read ##1 claimed |->
    dev_offset[19:0] == last_low)
    else $error("top alias offset wrong");
endmodule : rfb_props
bind rfb_rom_decode rfb_props u_props (.clk(clk), .rst_n(rst_n),
  .por_n(por_n), .bus_valid(bus_valid), .bus_addr(bus_addr),
  .bus_write(bus_write), .bus_size(bus_size), .bus_ack(bus_ack),
  .dev_sel_a(dev_sel_a), .dev_sel_b(dev_sel_b), .dev_write(dev_write),
  .dev_wide(dev_wide), .dev_offset(dev_offset));
`default_nettype wire

// ==== sim/rfb_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfb_rom_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       dev_sel_a,
  input  wire logic       dev_sel_b,
  input  wire logic       dev_write,
  output logic      [7:0] wr_a,
  output logic      [7:0] wr_b
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_a <= 8'h00;
      wr_b <= 8'h00;
    end else begin
      wr_a <= wr_a + 8'(dev_write && dev_sel_a);
      wr_b <= wr_b + 8'(dev_write && dev_sel_b);
    end
  end
endmodule : rfb_rom_model
`default_nettype wire

// ==== sim/rfb_rom_decode_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module rfb_rom_decode_bench;
  logic        clk = 0, rst_n = 0, por_n = 0, bus_valid = 0, bus_write = 0;
  logic [31:0] bus_addr = 0, bus_wdata = 0, bus_rdata, rd;
  logic [5:0]  bus_size = 0;
  logic        bus_ack, dev_sel_a, dev_sel_b, dev_write, dev_wide;
  logic [25:0] dev_offset, off;
  logic [3:0]  r;
  logic [3:0]  strap = 4'hf;
  logic        wd;
  logic [7:0]  wr_a, wr_b;
  int          n_mismatch = 0, compares = 0;
  always #5 clk = ~clk;
  rfb_rom_decode uut (.clk(clk), .rst_n(rst_n), .por_n(por_n),
    .strap_a_vector_pin(strap[0]), .strap_a_width_pin(strap[1]),
    .strap_b_vector_pin(strap[2]), .strap_b_width_pin(strap[3]),
    .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_write(bus_write),
    .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .dev_sel_a(dev_sel_a), .dev_sel_b(dev_sel_b),
    .dev_write(dev_write), .dev_wide(dev_wide), .dev_offset(dev_offset));
  rfb_rom_model rom (.clk(clk), .rst_n(rst_n), .dev_sel_a(dev_sel_a),
    .dev_sel_b(dev_sel_b), .dev_write(dev_write), .wr_a(wr_a), .wr_b(wr_b));
  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [5:0] s, input logic [31:0] d);
    @(negedge clk);
    bus_valid = 1;
    bus_write = w;
    bus_addr = a;
    bus_size = s;
    bus_wdata = d;
    @(negedge clk);
    bus_valid = 0;
    r = {bus_ack, dev_sel_b, dev_sel_a, dev_write};
    rd = bus_rdata;
    off = dev_offset;
    wd = dev_wide;
  endtask : acc
  task automatic cfg(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, 6'h04, d);
  endtask : cfg
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    por_n = 1;
    repeat (5) @(negedge clk);
    acc(1'b0, 32'hfef80050, 6'h04, 32'h0);
    `CHK(rd, 32'hff000104)
    acc(1'b0, 32'hfef80058, 6'h04, 32'h0);
    `CHK(rd, 32'hff400000)
    cfg(32'hfef80050, 32'h10320007); // clear of other slaves
    acc(1'b0, 32'hfef80050, 6'h04, 32'h0);
    `CHK(rd, 32'h10320107)
    $display("reset values and registers done");
    acc(1'b0, 32'h10000004, 6'h01, 32'h0);
    `CHK(r, 4'ha)
    `CHK(off, 26'h0000004)
    acc(1'b0, 32'h10400000, 6'h04, 32'h0);
    `CHK(r, 4'h0)
    acc(1'b1, 32'h10000008, 6'h04, 32'h0);
    `CHK(r, 4'hb)
    `CHK(wd, 1'b1)
    acc(1'b1, 32'h1000000a, 6'h04, 32'h0);
    `CHK(r, 4'h0)
    acc(1'b1, 32'h10000008, 6'h01, 32'h0);
    `CHK(r, 4'h0)
    acc(1'b1, 32'h10000008, 6'h02, 32'h0);
    `CHK(r, 4'h0)
    acc(1'b1, 32'h10000008, 6'h08, 32'h0);
    `CHK(r, 4'h0)
    cfg(32'hfef80050, 32'h10320006);
    acc(1'b1, 32'h10000008, 6'h04, 32'h0);
    `CHK(r, 4'ha)
    `CHK(wr_a, 8'h01)
    $display("block A access done");
    cfg(32'hfef80050, 32'h10370006);
    acc(1'b0, 32'h10000004, 6'h01, 32'h0);
    `CHK(r, 4'h0)
    cfg(32'hfef80050, 32'h10320004);
    acc(1'b0, 32'h10000004, 6'h01, 32'h0);
    `CHK(r, 4'h0)
    acc(1'b0, 32'hfff00010, 6'h04, 32'h0);
    `CHK(r, 4'ha)
    `CHK(off, 26'h0000010)
    $display("enable and reserved size done");
    cfg(32'hfef80058, 32'hff400007); // clear of other slaves
    acc(1'b0, 32'hfff00020, 6'h04, 32'h0);
    `CHK(r, 4'hc)
    `CHK(off, 26'h0000020)
    acc(1'b1, 32'hff400001, 6'h01, 32'h0);
    `CHK(r, 4'hd)
    `CHK(wd, 1'b0)
    acc(1'b1, 32'hff400004, 6'h04, 32'h0);
    `CHK(r, 4'h0)
    `CHK(wr_b, 8'h01)
    cfg(32'hfef80050, 32'h10320000);
    cfg(32'hfef80058, 32'hff400003);
    acc(1'b0, 32'hfff00020, 6'h04, 32'h0);
    `CHK(r, 4'h0)
    $display("block B and vector select done");
    cfg(32'hfef80050, 32'h10320004);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    acc(1'b0, 32'hfef80050, 6'h04, 32'h0);
    `CHK(rd, 32'hff000104)
    acc(1'b0, 32'hfef80058, 6'h04, 32'h0);
    `CHK(rd, 32'hff400000)
    $display("local reset done");
    rst_n = 1'b0;
    por_n = 1'b0;
    strap = 4'h0;
    @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b0, 32'hfef80050, 6'h04, 32'h0);
    `CHK(rd, 32'hff000000)
    acc(1'b0, 32'hfef80058, 6'h04, 32'h0);
    `CHK(rd, 32'hff400104)
    acc(1'b0, 32'hfff00030, 6'h04, 32'h0);
    `CHK(r, 4'hc)
    `CHK(off, 26'h0000030)
    `CHK(wd, 1'b1)
    cfg(32'hfef80050, 32'hff000100);
    acc(1'b0, 32'hfef80050, 6'h04, 32'h0);
    `CHK(rd, 32'hff000000)
    $display("power-up reset and straps done");
    end_of_test();
  end
endmodule : rfb_rom_decode_bench
`default_nettype wire
